// ### design/synth_port_map.svh
// offsets, field positions, reset values and counts of the serial load port
// assumes a 200 MHz core clock and a 32-bit APB with byte addresses
// Summary of operation
// R01: shift data in on each serial clock rise
// R02: host sends each word MSB first
// R03: two low bits pick destination latch
// R04: strobe rise copies word into one latch
// R05: enable low: power down, pump high-z
// R06: enable high powers up unless power-down bit
// R07: monitor pin shows lock or divided input
// R08: pump pulses only while enabled
// R09: host keeps strobe low while shifting
`ifndef SYNTH_PORT_MAP_SVH
`define SYNTH_PORT_MAP_SVH

`define WORD_W 24
`define DIV_W 14
`define LOCK_W 8
`define LOCK_COUNT 8'h20

// apb byte offsets
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_LATCH0 8'h10
`define OFS_LATCH1 8'h14
`define OFS_LATCH2 8'h18
`define OFS_LATCH3 8'h1C

// ctrl fields
`define CTRL_SW_PD 0
`define CTRL_RESET 32'h0000_0000

// status fields
`define STAT_POWERED 0
`define STAT_LOCK 1
`define STAT_CHIP_EN 2

// latch word fields
`define CTL_LSB 0
`define CTL_MSB 1
`define REF_DIV_LSB 2
`define REF_DIV_MSB 15
`define RF_DIV_LSB 8
`define RF_DIV_MSB 21
`define FN_PD_BIT 3
`define FN_MON_LSB 4
`define FN_MON_MSB 5
`define LATCH_REF 2'h0
`define LATCH_RF 2'h1
`define LATCH_FN 2'h2
`define LATCH_RESET 24'h00_0000

`endif

// ### design/synth_port_pkg.sv
// types shared by the serial load port modules
// assumes synth_port_map.svh is included first
`include "synth_port_map.svh"
package synth_port_pkg;
    typedef enum logic [1:0] {
        MON_LOCK,
        MON_RF_DIV,
        MON_REF_DIV,
        MON_LOW
    } mon_sel_t;

    typedef struct packed {
        logic sclk_prev;
        logic strobe_prev;
        logic [`WORD_W-1:0] word;
        logic load;
        logic [`WORD_W-1:0] load_word;
    } shift_state_t;

    typedef struct packed {
        logic prev;
        logic [`DIV_W-1:0] count;
        logic pulse;
        logic level;
    } div_state_t;

    typedef struct packed {
        logic [3:0][`WORD_W-1:0] latch;
        logic sw_pd;
        logic up;
        logic down;
        logic [`LOCK_W-1:0] lock_cnt;
        logic mon;
        logic pump_up;
        logic pump_down;
        logic [31:0] prdata;
        logic pslverr;
    } core_state_t;
endpackage

// ### design/shift_if.sv
// carries a completed serial word and its load pulse
// assumes one core clock domain on both ends
`include "synth_port_map.svh"
interface shift_if;
    logic [`WORD_W-1:0] word;
    logic load;
    modport src(output word, output load);
    modport dst(input word, input load);
endinterface

// ### design/serial_shift_in.sv
// 24-bit serial shifter with load strobe edge detect
// assumes pins already synchronous to core_clk
`include "synth_port_map.svh"
module serial_shift_in (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // serial pins
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    // completed word
    shift_if.src out
);
    synth_port_pkg::shift_state_t q, d;

    always_comb begin
        d = q;
        d.sclk_prev = serial_clk;
        d.strobe_prev = load_strobe;
        d.load = 1'b0;
        // R01: capture on rise
        if (serial_clk && !q.sclk_prev) begin
            d.word = {q.word[`WORD_W-2:0], serial_data};
        end
        // R04: strobe rise loads
        if (load_strobe && !q.strobe_prev) begin
            d.load = 1'b1;
            d.load_word = q.word;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign out.word = q.load_word;
    assign out.load = q.load;
endmodule

// ### design/edge_divider.sv
// divides rising edges of an input level by a programmed ratio
// ratio of zero behaves as one
`include "synth_port_map.svh"
module edge_divider (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // input and ratio
    input wire logic in_level,
    input wire logic [`DIV_W-1:0] ratio,
    // divided output
    output logic pulse,
    output logic level
);
    synth_port_pkg::div_state_t q, d;

    always_comb begin
        d = q;
        d.prev = in_level;
        d.pulse = 1'b0;
        if (in_level && !q.prev) begin
            if (q.count + `DIV_W'(1) >= ratio) begin
                d.count = '0;
                d.pulse = 1'b1;
                d.level = !q.level;
            end else begin
                d.count = q.count + `DIV_W'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pulse = q.pulse;
    assign level = q.level;
endmodule

// ### design/synth_serial_load_port.sv
// serial load port, latches, power control, phase detector and monitor pin
// assumes all pins synchronous to core_clk; apb slave with zero wait states
//
// Our own choices: the address map and the APB interface to the registers.
`include "synth_port_map.svh"
module synth_serial_load_port (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // serial programming pins
    input wire logic serial_clk,
    input wire logic serial_data,
    input wire logic load_strobe,
    input wire logic chip_enable,
    // frequency inputs
    input wire logic rf_in,
    input wire logic ref_in,
    // pump output, three-state
    output logic pump_up,
    output logic pump_down,
    output logic pump_output_oe,
    // monitor pin
    output logic monitor_output,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    synth_port_pkg::core_state_t q, d;
    synth_port_pkg::mon_sel_t mon_sel;
    shift_if sh();
    logic rf_pulse, rf_level, ref_pulse, ref_level;
    logic powered, locked;
    logic [`WORD_W-1:0] fn_latch;

    serial_shift_in u_shift (
        .core_clk(core_clk),
        .reset(reset),
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .load_strobe(load_strobe),
        .out(sh.src)
    );

    edge_divider u_rf_div (
        .core_clk(core_clk),
        .reset(reset),
        .in_level(rf_in),
        .ratio(q.latch[`LATCH_RF][`RF_DIV_MSB:`RF_DIV_LSB]),
        .pulse(rf_pulse),
        .level(rf_level)
    );

    edge_divider u_ref_div (
        .core_clk(core_clk),
        .reset(reset),
        .in_level(ref_in),
        .ratio(q.latch[`LATCH_REF][`REF_DIV_MSB:`REF_DIV_LSB]),
        .pulse(ref_pulse),
        .level(ref_level)
    );

    assign fn_latch = q.latch[`LATCH_FN];
    assign mon_sel = synth_port_pkg::mon_sel_t'(fn_latch[`FN_MON_MSB:`FN_MON_LSB]);
    // R05: R06: enable pin and power-down bit
    assign powered = chip_enable && !fn_latch[`FN_PD_BIT] && !q.sw_pd;
    assign locked = (q.lock_cnt == `LOCK_COUNT);

    always_comb begin
        d = q;
        // R03: R04: low bits pick the latch
        if (sh.load) begin
            d.latch[sh.word[`CTL_MSB:`CTL_LSB]] = sh.word;
        end

        // phase detector; both set means aligned, so clear
        if (!powered) begin
            d.up = 1'b0;
            d.down = 1'b0;
        end else begin
            d.up = q.up || ref_pulse;
            d.down = q.down || rf_pulse;
            if (d.up && d.down) begin
                d.up = 1'b0;
                d.down = 1'b0;
            end
        end

        // lock once the detector stays quiet long enough
        if (!powered || q.up || q.down) begin
            d.lock_cnt = '0;
        end else if (!locked) begin
            d.lock_cnt = q.lock_cnt + `LOCK_W'(1);
        end

        // R08: pulses only while enabled
        d.pump_up = powered && q.up;
        d.pump_down = powered && q.down;

        // R07: monitor source select
        case (mon_sel)
            synth_port_pkg::MON_LOCK: d.mon = locked;
            synth_port_pkg::MON_RF_DIV: d.mon = rf_level;
            synth_port_pkg::MON_REF_DIV: d.mon = ref_level;
            default: d.mon = 1'b0;
        endcase

        // apb: read data and error decided in setup, valid in access
        if (psel && !penable) begin
            d.pslverr = 1'b0;
            d.prdata = '0;
            case (paddr)
                `OFS_CTRL: d.prdata[`CTRL_SW_PD] = q.sw_pd;
                `OFS_STATUS: begin
                    d.prdata[`STAT_POWERED] = powered;
                    d.prdata[`STAT_LOCK] = locked;
                    d.prdata[`STAT_CHIP_EN] = chip_enable;
                end
                `OFS_LATCH0: d.prdata[`WORD_W-1:0] = q.latch[0];
                `OFS_LATCH1: d.prdata[`WORD_W-1:0] = q.latch[1];
                `OFS_LATCH2: d.prdata[`WORD_W-1:0] = q.latch[2];
                `OFS_LATCH3: d.prdata[`WORD_W-1:0] = q.latch[3];
                default: d.pslverr = 1'b1;
            endcase
        end
        // latches are read-only; only ctrl takes writes
        if (psel && penable && pwrite && paddr == `OFS_CTRL) begin
            d.sw_pd = pwdata[`CTRL_SW_PD];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign pump_up = q.pump_up;
    assign pump_down = q.pump_down;
    // R05: high impedance when powered down
    assign pump_output_oe = powered;
    assign monitor_output = q.mon;
    assign prdata = q.prdata;
    assign pslverr = q.pslverr && psel && penable;
    assign pready = psel && penable;
endmodule

// ### tb/serial_host.sv
// host model driving the serial programming pins
// assumes each call starts just after a core_clk edge
module serial_host (
    // clock
    input wire logic core_clk,
    // serial pins
    output logic serial_clk = 0,
    output logic serial_data = 0,
    output logic load_strobe = 0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            serial_data <= w[i];
            serial_clk <= 0;
            repeat (2) @(posedge core_clk);
            serial_clk <= 1;
            repeat (2) @(posedge core_clk);
        end
        serial_clk <= 0;
        // released data line must not look held
        serial_data <= ~w[0];
        @(posedge core_clk);
        load_strobe <= 1;
        repeat (2) @(posedge core_clk);
        load_strobe <= 0;
        repeat (3) @(posedge core_clk);
    endtask
endmodule

// ### tb/synth_port_chk.sv
// checker on the pump pins and apb slave of the load port
// assumes it is bound onto synth_serial_load_port
module synth_port_chk (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // pins
    input wire logic chip_enable,
    input wire logic pump_up,
    input wire logic pump_down,
    input wire logic pump_output_oe,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    wire logic rd = psel && penable && !pwrite;
    wire logic lat = rd && paddr[4];
    a_oe_off: assert property (!chip_enable |-> !pump_output_oe)
        else $error("pump driven while off");
    a_pump_quiet: assert property (!pump_output_oe [*3] |-> !pump_up && !pump_down)
        else $error("pump pulse while off");
    a_pump_gated: assert property (pump_up || pump_down |-> $past(pump_output_oe))
        else $error("pump pulse while not enabled");
    a_latch_width: assert property (lat |-> prdata[31:24] == 8'h00)
        else $error("latch wider than word");
    a_latch_sel: assert property (lat |-> prdata == 0 || prdata[1:0] == paddr[3:2])
        else $error("latch holds foreign word");
    a_status_power: assert property (rd && paddr == 8'h04 |-> !prdata[0] || prdata[2])
        else $error("powered without enable");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("wait state seen");
    a_unmapped_err: assert property (rd && paddr[7:5] != 0 |-> pslverr && prdata == 0)
        else $error("unmapped read accepted");
    c_latch_read: cover property (rd && paddr == 8'h1C);
    c_pump_up: cover property (pump_up);
    c_pump_down: cover property (pump_down);
    c_slave_err: cover property (pslverr);
endmodule
bind synth_serial_load_port synth_port_chk chk (
    .core_clk(core_clk),
    .reset(reset),
    .chip_enable(chip_enable),
    .pump_up(pump_up),
    .pump_down(pump_down),
    .pump_output_oe(pump_output_oe),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr)
);

// ### tb/tb.sv
// self-checking bench for the serial load port
// assumes the design files are compiled before it
`include "synth_port_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, reset = 1, chip_enable = 0, rf_in = 0, ref_in = 0;
    logic psel = 0, penable = 0, pwrite = 0, serial_clk, serial_data, load_strobe;
    logic pump_up, pump_down, pump_output_oe, monitor_output, pready, pslverr, er;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    int err_count = 0, total_checks = 0, ch, up, dn;
    synth_serial_load_port dut (
        .core_clk(core_clk),
        .reset(reset),
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .load_strobe(load_strobe),
        .chip_enable(chip_enable),
        .rf_in(rf_in),
        .ref_in(ref_in),
        .pump_up(pump_up),
        .pump_down(pump_down),
        .pump_output_oe(pump_output_oe),
        .monitor_output(monitor_output),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );
    serial_host host (
        .core_clk(core_clk),
        .serial_clk(serial_clk),
        .serial_data(serial_data),
        .load_strobe(load_strobe)
    );
    initial forever #2.5 core_clk = ~core_clk;
    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask
    task automatic t_latch;
        logic [23:0] v [4] = '{default: 0};
        for (int k = 0; k < 4; k++) begin
            v[k] = 24'hA5_3CF0 | 24'(k);
            host.send(v[k]);
            for (int j = 0; j < 4; j++) begin
                apb(0, `OFS_LATCH0 + 8'(4 * j), 0);
                chk("latch", {8'h00, v[j]}, rd);
            end
        end
        apb(0, 8'h40, 0);
        chk("slverr", 1, er);
    endtask
    task automatic t_power;
        chk("oe", 0, pump_output_oe);
        chip_enable <= 1;
        apb(0, `OFS_STATUS, 0);
        chk("status", 5, rd & 5);
        apb(1, `OFS_CTRL, 1);
        chk("oe ctrl", 0, pump_output_oe);
        apb(1, `OFS_CTRL, 0);
        chk("oe on", 1, pump_output_oe);
        host.send(24'h00_000A);
        chk("oe pd", 0, pump_output_oe);
    endtask
    task automatic pulses(input logic on_ref);
        logic m;
        ch = 0;
        up = 0;
        dn = 0;
        m = monitor_output;
        for (int i = 0; i < 64; i++) begin
            if (i % 4 == 0 && on_ref) ref_in <= ~ref_in;
            if (i % 4 == 0 && !on_ref) rf_in <= ~rf_in;
            @(posedge core_clk);
            ch += int'(monitor_output !== m);
            m = monitor_output;
            up += int'(pump_up === 1);
            dn += int'(pump_down === 1);
        end
    endtask
    task automatic t_freq;
        host.send(24'h00_0101);
        host.send(24'h00_0012);
        pulses(0);
        chk("mon rf", 8, ch);
        host.send(24'h00_0032);
        pulses(0);
        chk("mon low", 0, ch + monitor_output);
        host.send(24'h00_0004);
        pulses(1);
        chk("pump up", 1, up > 0);
        chip_enable <= 0;
        repeat (2) @(posedge core_clk);
        pulses(1);
        chk("pump off", 0, up);
    endtask
    task automatic t_mon;
        chip_enable <= 1;
        host.send(24'h00_0002);
        chk("mon lock", 1, monitor_output);
        apb(0, `OFS_STATUS, 0);
        chk("status lock", 7, rd & 7);
        host.send(24'h00_0022);
        pulses(1);
        chk("mon ref", 8, ch);
        pulses(0);
        chk("pump down", 1, dn > 0);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 0;
        @(posedge core_clk);
        t_latch;
        t_power;
        t_freq;
        t_mon;
        conclude;
    end
    initial begin
        #100000;
        err_count++;
        conclude;
    end
endmodule
